// *** src/ctm_defines.vh ***
// Purpose: constants shared by the compact timer design files
// Assumes: byte-wide timer registers, each in the low byte of one AXI word
// Notes:   definitions only
`ifndef CTM_DEFINES_VH
`define CTM_DEFINES_VH

// ==========================================================
// register byte addresses
`define CTM_ADDR_CTRL0    8'h00
`define CTM_ADDR_CTRL1    8'h04
`define CTM_ADDR_CNT_LO   8'h08
`define CTM_ADDR_CNT_HI   8'h0C
`define CTM_ADDR_CMPA_LO  8'h10
`define CTM_ADDR_CMPA_HI  8'h14
`define CTM_ADDR_INT_STAT 8'h18
`define CTM_ADDR_INT_CLR  8'h1C
`define CTM_ADDR_INT_EN   8'h20

// ==========================================================
// control register 0 fields
`define CTM_C0_PAUSE      7
`define CTM_C0_CKSEL_HI   6
`define CTM_C0_CKSEL_LO   4
`define CTM_C0_ON         3
`define CTM_C0_PER_HI     2
`define CTM_C0_PER_LO     0

// control register 1 fields
`define CTM_C1_MODE_HI    7
`define CTM_C1_MODE_LO    6
`define CTM_C1_IO_HI      5
`define CTM_C1_IO_LO      4
`define CTM_C1_OC         3
`define CTM_C1_POL        2
`define CTM_C1_DPX        1
`define CTM_C1_CCLR       0

// interrupt bits
`define CTM_INT_A         0
`define CTM_INT_P         1

// ==========================================================
// modes, pin actions, clock sources
`define CTM_MODE_CMP      2'h0
`define CTM_MODE_PWM      2'h2
`define CTM_MODE_TMR      2'h3
`define CTM_IO_NONE       2'h0
`define CTM_IO_LOW        2'h1
`define CTM_IO_HIGH       2'h2
`define CTM_IO_TOGGLE     2'h3
`define CTM_IO_PWM        2'h2
`define CTM_CK_SYS4       3'h0
`define CTM_CK_SYS        3'h1
`define CTM_CK_H16        3'h2
`define CTM_CK_H64        3'h3
`define CTM_CK_SUB0       3'h4
`define CTM_CK_SUB1       3'h5
`define CTM_CK_EXT_RISE   3'h6
`define CTM_CK_EXT_FALL   3'h7

// ==========================================================
// dividers, widths, reset values, bus answers
`define CTM_DIV_SYS       7'h04
`define CTM_DIV_H16       7'h10
`define CTM_DIV_H64       7'h40
`define CTM_CNT_ZERO      10'h000
`define CTM_CNT_ONE       10'h001
`define CTM_LOW_PAD       7'h00
`define CTM_BYTE_ZERO     8'h00
`define CTM_INT_ZERO      2'h0
`define CTM_RESP_OKAY     2'h0
`define CTM_RESP_SLVERR   2'h2

`endif

// *** src/ctm_sync.v ***
// Purpose: bring the external count pin into the mclk domain and find its edges
// Assumes: pin is asynchronous to mclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ns
module ctm_sync (
  input  wire mclk,     // system clock
  input  wire nrst,     // synchronous reset, active low
  input  wire pin_in,   // asynchronous pin
  output wire rise,     // one-cycle pulse on a rising edge
  output wire fall      // one-cycle pulse on a falling edge
);
  reg stage1_reg;
  reg stage2_reg;
  reg stage3_reg;

  always @(posedge mclk) begin
    if (!nrst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
      stage3_reg <= 1'b0;
    end else begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  assign rise = stage2_reg & ~stage3_reg;
  assign fall = ~stage2_reg & stage3_reg;
endmodule

// *** src/ctm_div.v ***
// Purpose: divide a tick stream by a fixed ratio
// Assumes: tick_in is a one-cycle pulse on mclk
// Notes:   output is a registered one-cycle pulse
`timescale 1ns/1ns
module ctm_div #(
  parameter [6:0] DIV = 7'h04
) (
  input  wire mclk,      // system clock
  input  wire nrst,      // synchronous reset, active low
  input  wire tick_in,   // input tick
  output reg  tick_out   // one tick every DIV input ticks
);
  reg  [6:0] cnt_reg;
  wire [6:0] last = DIV - 7'h01;

  always @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg  <= 7'h00;
      tick_out <= 1'b0;
    end else begin
      tick_out <= 1'b0;
      if (tick_in) begin
        if (cnt_reg == last) begin
          cnt_reg  <= 7'h00;
          tick_out <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 7'h01;
        end
      end
    end
  end
endmodule

// *** src/ctm_top.v ***
// Purpose: compact 10-bit timer with AXI4-Lite register access
// Assumes: fh_tick and fsub_tick are one-cycle pulses made on mclk
// Notes:   all timer registers are byte wide, in the low byte of each word
//
// What this block does
// R1: ten-bit up-counter advancing on each active edge of the chosen clock.
// R2: comparator P matches the three-bit period against counter bits nine to seven.
// R3: comparator A matches the ten-bit value against the whole counter.
// R4: software can only clear the counter, by raising the enable bit.
// R5: counter clears on overflow or selected comparator match, raising an interrupt.
// R6: separate interrupt requests for comparator A and comparator P matches.
// R7: counter clock chosen from system and high clock divisions, the sub clock or the pin.
// R8: external pin counts rising or falling edges as selected.
// R9: compare mode drives the pin high, low or toggles it on match.
// R10: edge-aligned PWM on the same pin, duty or period adjustable.
// R11: only compare output, timer/counter and PWM modes exist.
// R12: low bytes reached through one shared 8-bit buffer, moved on high accesses.
// R13: low write fills buffer; high write updates high and copies buffer low.
// R14: high read returns high and latches low; low read returns the buffer.
// R15: software writes low then high, reads high then low.
// R16: period field times 128 clocks sets P match; zero means 1024-count overflow.
// R17: mode 00 compare, 10 PWM, 11 timer/counter, 01 undefined.
// R18: pause freezes the counter; clearing pause resumes from the held value.
// R19: external pin passes a two-stage synchroniser before its edge is used.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "ctm_defines.vh"
module ctm_top (
  input  wire        mclk,             // system clock, 100 MHz
  input  wire        nrst,             // synchronous reset, active low
  input  wire        fh_tick,          // high internal clock tick
  input  wire        fsub_tick,        // sub clock tick
  input  wire        ext_clock_pin,    // external count pin, asynchronous
  output wire        timer_output_pin, // timer output pin
  output wire        irq,              // level interrupt
  input  wire [7:0]  awaddr,           // write address
  input  wire        awvalid,          // write address valid
  output wire        awready,          // write address ready
  input  wire [31:0] wdata,            // write data
  input  wire [3:0]  wstrb,            // write strobes
  input  wire        wvalid,           // write data valid
  output wire        wready,           // write data ready
  output reg  [1:0]  bresp,            // write response
  output reg         bvalid,           // write response valid
  input  wire        bready,           // write response ready
  input  wire [7:0]  araddr,           // read address
  input  wire        arvalid,          // read address valid
  output wire        arready,          // read address ready
  output reg  [31:0] rdata,            // read data
  output reg  [1:0]  rresp,            // read response
  output reg         rvalid,           // read data valid
  input  wire        rready            // read data ready
);
  // ==========================================================
  // registers
  reg  [7:0] ctrl0_reg;
  reg  [7:0] ctrl1_reg;
  reg  [9:0] cnt_reg;
  reg  [9:0] cmpa_reg;
  reg  [7:0] buf_reg;
  reg  [1:0] int_stat_reg;
  reg  [1:0] int_en_reg;
  reg        on_prev_reg;
  reg        out_reg;
  reg        aw_full_reg;
  reg  [7:0] aw_addr_reg;
  reg        w_full_reg;
  reg  [7:0] w_data_reg;
  reg        w_lane0_reg;

  wire       pause   = ctrl0_reg[`CTM_C0_PAUSE];
  wire [2:0] cksel   = ctrl0_reg[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
  wire       ctm_on  = ctrl0_reg[`CTM_C0_ON];
  wire [2:0] period  = ctrl0_reg[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
  wire [1:0] mode    = ctrl1_reg[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  wire [1:0] io_sel  = ctrl1_reg[`CTM_C1_IO_HI:`CTM_C1_IO_LO];
  wire       oc      = ctrl1_reg[`CTM_C1_OC];
  wire       pol     = ctrl1_reg[`CTM_C1_POL];
  wire       dpx     = ctrl1_reg[`CTM_C1_DPX];
  wire       cclr    = ctrl1_reg[`CTM_C1_CCLR];

  // ==========================================================
  // clock sources
  wire ext_rise;
  wire ext_fall;
  wire sys4_tick;
  wire h16_tick;
  wire h64_tick;

  ctm_sync u_sync (                      // R19
    .mclk   (mclk),
    .nrst   (nrst),
    .pin_in (ext_clock_pin),
    .rise   (ext_rise),
    .fall   (ext_fall)
  );

  ctm_div #(.DIV(`CTM_DIV_SYS)) u_div_sys4 (
    .mclk     (mclk),
    .nrst     (nrst),
    .tick_in  (1'b1),
    .tick_out (sys4_tick)
  );

  ctm_div #(.DIV(`CTM_DIV_H16)) u_div_h16 (
    .mclk     (mclk),
    .nrst     (nrst),
    .tick_in  (fh_tick),
    .tick_out (h16_tick)
  );

  ctm_div #(.DIV(`CTM_DIV_H64)) u_div_h64 (
    .mclk     (mclk),
    .nrst     (nrst),
    .tick_in  (fh_tick),
    .tick_out (h64_tick)
  );

  reg src_tick;
  always @* begin
    case (cksel)                         // R7
      `CTM_CK_SYS4:     src_tick = sys4_tick;
      `CTM_CK_SYS:      src_tick = 1'b1;
      `CTM_CK_H16:      src_tick = h16_tick;
      `CTM_CK_H64:      src_tick = h64_tick;
      `CTM_CK_SUB0:     src_tick = fsub_tick;
      `CTM_CK_SUB1:     src_tick = fsub_tick;
      `CTM_CK_EXT_RISE: src_tick = ext_rise; // R8
      `CTM_CK_EXT_FALL: src_tick = ext_fall; // R8
      default:          src_tick = 1'b0;
    endcase
  end

  // ==========================================================
  // counter and comparators
  // a match is seen on the tick that moves the counter onto the compare
  // value, so the cycle count of a period equals the compare value exactly
  wire       on_rise    = ctm_on & ~on_prev_reg;
  wire       count_tick = ctm_on & ~pause & src_tick;       // R18
  wire [9:0] cnt_inc    = cnt_reg + `CTM_CNT_ONE;           // R1
  wire       p_hit      = count_tick && (cnt_inc[9:7] == period) &&
                          (cnt_inc[6:0] == `CTM_LOW_PAD);   // R2 R16
  wire       a_hit      = count_tick && (cnt_inc == cmpa_reg); // R3
  // in PWM mode the period comparator follows the duty/period choice
  wire       clr_on_a   = (mode == `CTM_MODE_PWM) ? dpx : cclr;
  wire       cnt_clear  = clr_on_a ? a_hit : p_hit;

  always @(posedge mclk) begin
    if (!nrst) begin
      cnt_reg     <= `CTM_CNT_ZERO;
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= ctm_on;
      if (on_rise)
        cnt_reg <= `CTM_CNT_ZERO;        // R4
      else if (count_tick)
        cnt_reg <= cnt_clear ? `CTM_CNT_ZERO : cnt_inc; // R1 R5
    end
  end

  // ==========================================================
  // output pin
  wire pwm_active = dpx ? (cnt_reg < {period, `CTM_LOW_PAD}) : (cnt_reg < cmpa_reg);

  always @(posedge mclk) begin
    if (!nrst) begin
      out_reg <= 1'b0;
    end else begin
      case (mode)                        // R11 R17
        `CTM_MODE_CMP: begin
          if (on_rise)
            out_reg <= oc;
          else if (a_hit) begin
            case (io_sel)                // R9
              `CTM_IO_LOW:    out_reg <= 1'b0;
              `CTM_IO_HIGH:   out_reg <= 1'b1;
              `CTM_IO_TOGGLE: out_reg <= ~out_reg;
              default:        out_reg <= out_reg;
            endcase
          end
        end
        `CTM_MODE_PWM: begin
          case (io_sel)                  // R10
            `CTM_IO_NONE: out_reg <= ~oc;
            `CTM_IO_LOW:  out_reg <= oc;
            `CTM_IO_PWM:  out_reg <= (pwm_active & ctm_on) ? oc : ~oc;
            default:      out_reg <= out_reg;
          endcase
        end
        default: out_reg <= out_reg;     // timer mode and code 01 leave the pin
      endcase
    end
  end

  assign timer_output_pin = out_reg ^ pol;

  // ==========================================================
  // bus handshakes
  assign awready = ~aw_full_reg;
  assign wready  = ~w_full_reg;
  assign arready = ~rvalid;

  wire aw_take  = awvalid & ~aw_full_reg;
  wire w_take   = wvalid & ~w_full_reg;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid;
  wire do_read  = arvalid & ~rvalid;
  wire wr_en    = do_write & w_lane0_reg;

  wire wr_hit = (aw_addr_reg == `CTM_ADDR_CTRL0)    || (aw_addr_reg == `CTM_ADDR_CTRL1)   ||
                (aw_addr_reg == `CTM_ADDR_CNT_LO)   || (aw_addr_reg == `CTM_ADDR_CNT_HI)  ||
                (aw_addr_reg == `CTM_ADDR_CMPA_LO)  || (aw_addr_reg == `CTM_ADDR_CMPA_HI) ||
                (aw_addr_reg == `CTM_ADDR_INT_STAT) || (aw_addr_reg == `CTM_ADDR_INT_CLR) ||
                (aw_addr_reg == `CTM_ADDR_INT_EN);

  reg [7:0] rd_byte;
  reg       rd_hit;
  always @* begin
    rd_hit  = 1'b1;
    case (araddr)
      `CTM_ADDR_CTRL0:    rd_byte = ctrl0_reg;
      `CTM_ADDR_CTRL1:    rd_byte = ctrl1_reg;
      `CTM_ADDR_CNT_LO:   rd_byte = buf_reg;                    // R14
      `CTM_ADDR_CNT_HI:   rd_byte = {6'h00, cnt_reg[9:8]};
      `CTM_ADDR_CMPA_LO:  rd_byte = buf_reg;                    // R14
      `CTM_ADDR_CMPA_HI:  rd_byte = {6'h00, cmpa_reg[9:8]};
      `CTM_ADDR_INT_STAT: rd_byte = {6'h00, int_stat_reg};
      `CTM_ADDR_INT_CLR:  rd_byte = `CTM_BYTE_ZERO;
      `CTM_ADDR_INT_EN:   rd_byte = {6'h00, int_en_reg};
      default: begin
        rd_byte = `CTM_BYTE_ZERO;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // bus state and register writes
  always @(posedge mclk) begin
    if (!nrst) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= `CTM_BYTE_ZERO;
      w_full_reg  <= 1'b0;
      w_data_reg  <= `CTM_BYTE_ZERO;
      w_lane0_reg <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= `CTM_RESP_OKAY;
      rvalid      <= 1'b0;
      rresp       <= `CTM_RESP_OKAY;
      rdata       <= 32'h0000_0000;
      ctrl0_reg   <= `CTM_BYTE_ZERO;
      ctrl1_reg   <= `CTM_BYTE_ZERO;
      cmpa_reg    <= `CTM_CNT_ZERO;
      buf_reg     <= `CTM_BYTE_ZERO;
      int_en_reg  <= `CTM_INT_ZERO;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= awaddr;
      end
      if (w_take) begin
        w_full_reg  <= 1'b1;
        w_data_reg  <= wdata[7:0];
        w_lane0_reg <= wstrb[0];
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (rvalid && rready)
        rvalid <= 1'b0;

      if (do_read) begin
        rvalid <= 1'b1;
        rresp  <= rd_hit ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
        rdata  <= {24'h00_0000, rd_byte};
        if (araddr == `CTM_ADDR_CNT_HI)
          buf_reg <= cnt_reg[7:0];       // R12 R14
        if (araddr == `CTM_ADDR_CMPA_HI)
          buf_reg <= cmpa_reg[7:0];      // R12 R14
      end

      // a write placed after the read lets it win the shared buffer
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= wr_hit ? `CTM_RESP_OKAY : `CTM_RESP_SLVERR;
      end
      if (wr_en) begin
        case (aw_addr_reg)
          `CTM_ADDR_CTRL0:   ctrl0_reg  <= w_data_reg;
          `CTM_ADDR_CTRL1:   ctrl1_reg  <= w_data_reg;
          `CTM_ADDR_CMPA_LO: buf_reg    <= w_data_reg;                  // R13
          `CTM_ADDR_CMPA_HI: cmpa_reg   <= {w_data_reg[1:0], buf_reg};  // R12 R13
          `CTM_ADDR_INT_EN:  int_en_reg <= w_data_reg[1:0];
          default:           ctrl0_reg  <= ctrl0_reg;   // counter pair is read-only
        endcase
      end
    end
  end

  // ==========================================================
  // interrupts: a new event beats a clear in the same cycle
  wire [1:0] int_set = {p_hit, a_hit};                                 // R5 R6
  wire [1:0] int_clr = (wr_en && aw_addr_reg == `CTM_ADDR_INT_CLR) ?
                       w_data_reg[1:0] : `CTM_INT_ZERO;

  always @(posedge mclk) begin
    if (!nrst)
      int_stat_reg <= `CTM_INT_ZERO;
    else
      int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;             // R6
  end

  assign irq = |(int_stat_reg & int_en_reg);
endmodule

// *** tb/ctm_partner.sv ***
// Purpose: far-side model of the timer pins and slow tick inputs
// Assumes: bursts are requested from the bench, on mclk
// Notes:   the pin and both ticks idle low
`timescale 1ns/1ns
module ctm_partner (
  output reg  fh_tick,       // high clock tick
  output reg  fsub_tick,     // sub clock tick
  output reg  ext_clock_pin, // external count pin
  input  wire mclk           // system clock
);
  initial begin
    fh_tick = 1'b0;
    fsub_tick = 1'b0;
    ext_clock_pin = 1'b0;
  end
  // ==========================================================
  // n events on the source picked by sel
  task pulse(input [2:0] sel, input integer n);
    integer i;
    integer k;
    begin
      for (i = 0; i < n; i = i + 1) begin
        for (k = 0; k < 8; k = k + 1) begin
          @(posedge mclk);
          // levels held four cycles so the synchroniser never drops an edge
          if (sel[2:1] == 2'b11) ext_clock_pin <= (k < 4);
          else if (sel[2]) fsub_tick <= (k == 0);
          else fh_tick <= (k == 0);
        end
      end
    end
  endtask
endmodule

// *** tb/ctm_top_monitor.sv ***
// Purpose: port-level checks of the compact timer
// Assumes: single mclk domain, nrst synchronous active low
// Notes:   bound to every ctm_top instance
`timescale 1ns/1ns
module ctm_monitor (
  input wire        mclk,             // system clock
  input wire        nrst,             // reset, active low
  input wire        awvalid,          // write address valid
  input wire        awready,          // write address ready
  input wire        wvalid,           // write data valid
  input wire        wready,           // write data ready
  input wire [1:0]  bresp,            // write response
  input wire        bvalid,           // write response valid
  input wire        bready,           // write response ready
  input wire        arvalid,          // read address valid
  input wire        arready,          // read address ready
  input wire [31:0] rdata,            // read data
  input wire [1:0]  rresp,            // read response
  input wire        rvalid,           // read data valid
  input wire        rready,           // read data ready
  input wire        irq,              // level interrupt
  input wire        timer_output_pin  // timer output
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // bus answers, reset state and coverage
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped early");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  rd_latency_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  ar_block_a: assert property (arready == !rvalid)
    else $error("read address ready wrong");
  wr_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer late");
  aw_refuse_a: assert property (awvalid && awready |=> !awready)
    else $error("second address accepted");
  byte_pad_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  err_data_a: assert property (rvalid && rresp == 2'h2 |-> rdata == 32'h0000_0000)
    else $error("error read carries data");
  rst_clean_a: assert property ($rose(nrst) |-> !irq && !timer_output_pin && !bvalid && !rvalid)
    else $error("outputs not clear after reset");
  irq_seen_c: cover property ($rose(irq));
  pin_seen_c: cover property ($rose(timer_output_pin));
  err_seen_c: cover property (rvalid && rresp == 2'h2);
endmodule

bind ctm_top ctm_monitor u_ctm_monitor (
  .mclk(mclk), .nrst(nrst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready), .irq(irq), .timer_output_pin(timer_output_pin)
);

// *** tb/tb_ctm_top.sv ***
// Purpose: register-level tests of the compact timer
// Assumes: AXI4-Lite master tasks, partner drives pins and ticks
// Notes:   ready and valid are sampled at the falling edge, acted on at the rising edge
`timescale 1ns/1ns
`include "ctm_defines.vh"
module tb_ctm_top;
  reg         mclk, nrst, awvalid, wvalid, bready, arvalid, rready, hung;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rd_data;
  reg  [3:0]  wstrb;
  reg  [1:0]  rd_resp, wr_resp;
  wire        fh_tick, fsub_tick, ext_clock_pin, timer_output_pin, irq;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     error_cnt, cmp_count, i, n, v, s;

  ctm_partner u_ctm_partner (.fh_tick(fh_tick), .fsub_tick(fsub_tick), .ext_clock_pin(ext_clock_pin), .mclk(mclk));
  ctm_top u_ctm_top (
    .mclk(mclk), .nrst(nrst), .fh_tick(fh_tick), .fsub_tick(fsub_tick), .ext_clock_pin(ext_clock_pin),
    .timer_output_pin(timer_output_pin), .irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready)
  );

  always #5 mclk = ~mclk;
  always @(posedge hung) final_report();
  // ==========================================================
  // reporting
  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("errors=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  task stuck(input integer k);
    begin
      if (k >= 50) begin
        error_cnt = error_cnt + 1;
        hung = 1'b1;
      end
    end
  endtask
  // ==========================================================
  // bus master
  task wr(input [7:0] a, input [31:0] d);
    reg aw_ok, w_ok;
    begin
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (i = 0; i < 50 && !(aw_ok && w_ok); i = i + 1) begin
        @(negedge mclk);
        if (awready === 1'b1) aw_ok = 1'b1;
        if (wready === 1'b1) w_ok = 1'b1;
        @(posedge mclk);
        if (aw_ok) awvalid <= 1'b0;
        if (w_ok) wvalid <= 1'b0;
      end
      stuck(i);
      for (i = 0; i < 50 && bvalid !== 1'b1; i = i + 1) @(negedge mclk);
      stuck(i);
      // ready comes one cycle late so the answer must be held
      @(posedge mclk);
      bready <= 1'b1;
      @(negedge mclk);
      wr_resp = bresp;
      @(posedge mclk);
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      for (i = 0; i < 50 && arready !== 1'b1; i = i + 1) @(negedge mclk);
      stuck(i);
      @(posedge mclk);
      arvalid <= 1'b0;
      for (i = 0; i < 50 && rvalid !== 1'b1; i = i + 1) @(negedge mclk);
      stuck(i);
      @(posedge mclk);
      rready <= 1'b1;
      @(negedge mclk);
      rd_data = rdata;
      rd_resp = rresp;
      @(posedge mclk);
      rready <= 1'b0;
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] exp);
    begin
      rd(a);
      check(rd_data, exp);
    end
  endtask
  // cycles between two changes of the timer pin
  task pin_gap(output integer gap);
    reg last;
    begin
      gap = 0;
      @(negedge mclk);
      last = timer_output_pin;
      for (i = 0; i < 60 && timer_output_pin === last; i = i + 1) @(negedge mclk);
      last = timer_output_pin;
      for (i = 0; i < 60 && timer_output_pin === last; i = i + 1) begin
        @(negedge mclk);
        gap = gap + 1;
      end
    end
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (60000) @(posedge mclk);
    error_cnt = error_cnt + 1;
    final_report();
  end
  initial begin
    mclk = 1'b0; nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    hung = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000; wstrb = 4'hF;
    error_cnt = 0; cmp_count = 0;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    for (v = 0; v <= 32; v = v + 4) if (v != 28) rdchk(v[7:0], 32'h0000_0000);
    rd(8'h24);
    check(32'(rd_resp), 32'(`CTM_RESP_SLVERR));
    wr(8'h24, 32'h0000_0001);
    check(32'(wr_resp), 32'(`CTM_RESP_SLVERR));
    wr(`CTM_ADDR_CNT_HI, 32'h0000_0003);
    check(32'(wr_resp), 32'(`CTM_RESP_OKAY));
    rdchk(`CTM_ADDR_CNT_HI, 32'h0000_0000);
    wr(`CTM_ADDR_CMPA_LO, 32'h0000_00A5);
    wr(`CTM_ADDR_CMPA_HI, 32'h0000_0002);
    wr(`CTM_ADDR_CMPA_LO, 32'h0000_0077);
    rdchk(`CTM_ADDR_CMPA_HI, 32'h0000_0002);
    rdchk(`CTM_ADDR_CMPA_LO, 32'h0000_00A5);
    rdchk(`CTM_ADDR_CNT_HI, 32'h0000_0000);
    rdchk(`CTM_ADDR_CMPA_LO, 32'h0000_0000);
    wr(`CTM_ADDR_CMPA_LO, 32'h0000_0005);
    wr(`CTM_ADDR_CMPA_HI, 32'h0000_0000);
    wr(`CTM_ADDR_INT_EN, 32'h0000_0003);
    wr(`CTM_ADDR_CTRL1, 32'h0000_0031);
    wr(`CTM_ADDR_CTRL0, 32'h0000_0018);
    pin_gap(n);
    check(n, 5);
    rdchk(`CTM_ADDR_INT_STAT, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wr(`CTM_ADDR_CTRL0, 32'h0000_0098);
    rd(`CTM_ADDR_CNT_HI);
    rd(`CTM_ADDR_CNT_LO);
    v = rd_data;
    repeat (20) @(posedge mclk);
    rdchk(`CTM_ADDR_CNT_HI, 32'h0000_0000);
    rdchk(`CTM_ADDR_CNT_LO, v);
    wr(`CTM_ADDR_CTRL0, 32'h0000_0010);
    wr(`CTM_ADDR_INT_CLR, 32'h0000_0003);
    rdchk(`CTM_ADDR_INT_STAT, 32'h0000_0000);
    check(32'(irq), 32'h0000_0000);
    wr(`CTM_ADDR_INT_EN, 32'h0000_0000);
    wr(`CTM_ADDR_CTRL0, 32'h0000_0018);
    repeat (20) @(posedge mclk);
    check(32'(irq), 32'h0000_0000);
    wr(`CTM_ADDR_INT_EN, 32'h0000_0001);
    check(32'(irq), 32'h0000_0001);
    wr(`CTM_ADDR_CTRL0, 32'h0000_0010);
    wr(`CTM_ADDR_INT_CLR, 32'h0000_0003);
    wr(`CTM_ADDR_CTRL1, 32'h0000_00C0);
    wr(`CTM_ADDR_CTRL0, 32'h0000_0019);
    repeat (300) @(posedge mclk);
    rdchk(`CTM_ADDR_CNT_HI, 32'h0000_0000);
    rdchk(`CTM_ADDR_INT_STAT, 32'h0000_0003);
    wr(`CTM_ADDR_CTRL1, 32'h0000_00C1);
    // the h64 divider keeps 48 ticks from the h16 pass, so 192 more still give 3 counts
    for (s = 2; s < 8; s = s + 1) begin
      wr(`CTM_ADDR_CTRL0, 32'(s << 4));
      wr(`CTM_ADDR_CTRL0, 32'((s << 4) | 8));
      u_ctm_partner.pulse(s[2:0], (s == 2) ? 3 * `CTM_DIV_H16 : (s == 3) ? 3 * `CTM_DIV_H64 : 3);
      repeat (5) @(posedge mclk);
      rdchk(`CTM_ADDR_CNT_HI, 32'h0000_0000);
      rdchk(`CTM_ADDR_CNT_LO, 32'h0000_0003);
    end
    wr(`CTM_ADDR_CTRL0, 32'h0000_0010);
    wr(`CTM_ADDR_CTRL1, 32'h0000_00A8);
    wr(`CTM_ADDR_CTRL0, 32'h0000_0019);
    repeat (200) @(posedge mclk);
    n = 0;
    repeat (128) begin
      @(negedge mclk);
      if (timer_output_pin === 1'b1) n = n + 1;
    end
    check(n, 5);
    wr(`CTM_ADDR_CTRL1, 32'h0000_00AC);
    n = 0;
    repeat (128) begin
      @(negedge mclk);
      if (timer_output_pin === 1'b1) n = n + 1;
    end
    check(n, 123);
    final_report();
  end
endmodule
